// ==== rtl/wrs_pkg.sv ====
/*
 * shared constants and types of the watchdog, reset and sleep control block:
 * register addresses, field positions, reset values, timing figures, states.
 * assumes a 250 MHz reference clock that also stands for the system clock.
 */
package wrs_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h00FA;  // main register file
    localparam logic [7:0] ADDR_STOP_REC  = 8'h000B;  // bank f, expanded group
    localparam logic [7:0] ADDR_WDT_MODE  = 8'h000F;  // bank f, expanded group

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int HOT_BIT       = 7;
    localparam int WAKE_CAUSE    = 7;
    localparam int WAKE_LEVEL    = 6;
    localparam int POR_ON_WAKE   = 5;
    localparam int SRC_LSB       = 2;
    localparam int SRC_MSB       = 4;
    localparam int HALT_RUN      = 2;
    localparam int STOP_RUN      = 3;
    localparam int PER_LSB       = 0;
    localparam int PER_MSB       = 1;
    localparam logic [6:0] STOP_REC_RST = 7'h0020;  // slow wake, low level, reset only
    localparam logic [3:0] WDT_MODE_RST = 4'h000C;  // run in halt and stop, shortest period

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_KHZ        = 250_000;
    localparam int WDT_MS0        = 4;
    localparam int WDT_MS1        = 9;
    localparam int WDT_MS2        = 18;
    localparam int WDT_MS3        = 75;
    localparam int POR_MS         = 150;
    localparam int WDT_CYC0       = WDT_MS0 * CLK_KHZ;
    localparam int WDT_CYC1       = WDT_MS1 * CLK_KHZ;
    localparam int WDT_CYC2       = WDT_MS2 * CLK_KHZ;
    localparam int WDT_CYC3       = WDT_MS3 * CLK_KHZ;
    localparam int POR_CYC        = POR_MS * CLK_KHZ;
    localparam int PIN_LOW_TPC    = 6;
    localparam int LOOP_RST_TPC   = 18;
    localparam int WRITE_WIN_TPC  = 64;
    localparam int FAST_WAKE_TPC  = 5;
    localparam logic [15:0] RESTART_ADDR = 16'h000C;
    localparam int CNT_W          = 27;
    localparam int SEQ_W          = 7;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_RUN   = 2'b01,
        ST_HALT  = 2'b10,
        ST_STOP  = 2'b11
    } wrs_state_t;

    typedef struct packed {
        logic       bank_f;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } wrs_reg_req_t;

    typedef struct packed {
        logic [3:0] port0_low;
        logic [7:0] port2;
        logic [3:0] port3_in;
    } wrs_wake_pins_t;

endpackage : wrs_pkg

// ==== rtl/wrs_oneshot.sv ====
/*
 * retriggerable one-shot down counter: load restarts the count, run lets it
 * advance, done pulses for one cycle when the count reaches zero.
 * assumes load and run are synchronous to clk.
 */
`timescale 1ns/10ps
module wrs_oneshot #(
    parameter int CNT_W = 27
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // control
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic             run,
    // status
    output logic                  busy,
    output logic                  done
);

    logic [CNT_W-1:0] count;
    wire              last = busy && run && (count == CNT_W'(1));

    // count down while armed, stop at zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= last && !load;
            if (load) begin
                count <= load_val;
                busy  <= 1'b1;
            end else if (busy && run) begin
                count <= count - CNT_W'(1);
                busy  <= !last;
            end
        end
    end

endmodule : wrs_oneshot

// ==== rtl/wrs_wake_sel.sv ====
/*
 * stop-mode wake source selector: picks a pin or pin group by code and
 * compares it with the chosen active level.
 * assumes pins are synchronous to the clock.
 */
`timescale 1ns/10ps
module wrs_wake_sel (
    // pins
    input  wire wrs_pkg::wrs_wake_pins_t pins,
    // selection
    input  wire logic [2:0]              src,
    input  wire logic                    level_high,
    // result
    output logic                         wake
);

    // group gates expressed so that a low-level setting means any or all low
    wire grp_a  = &{pins.port0_low, pins.port3_in, pins.port2[6:4]};
    wire grp_b  = &{pins.port0_low, pins.port3_in[1], pins.port3_in[3], pins.port2[6:4]};
    wire grp_c  = |pins.port2[3:0];
    logic sel;

    // source code select, code zero never wakes
    always_comb begin
        sel = level_high ? 1'b0 : 1'b1;
        unique case (src)
            3'b000: sel = level_high ? 1'b0 : 1'b1;
            3'b001: sel = grp_a;
            3'b010: sel = pins.port3_in[1];
            3'b011: sel = pins.port3_in[2];
            3'b100: sel = pins.port3_in[3];
            3'b101: sel = pins.port2[7];
            3'b110: sel = grp_c;
            3'b111: sel = grp_b;
        endcase
    end

    assign wake = (sel == level_high);

endmodule : wrs_wake_sel

// ==== rtl/wrs_top.sv ====
/*
 * watchdog, power-on-reset timer, warm/cold flags and halt/stop sleep control.
 * assumes the cpu core pulses refresh, halt and stop when it executes them,
 * and that register requests arrive one per cycle from the core.
 */
`timescale 1ns/10ps
module wrs_top #(
    parameter int WDT_CYC0 = wrs_pkg::WDT_CYC0,
    parameter int WDT_CYC1 = wrs_pkg::WDT_CYC1,
    parameter int WDT_CYC2 = wrs_pkg::WDT_CYC2,
    parameter int WDT_CYC3 = wrs_pkg::WDT_CYC3,
    parameter int POR_CYC  = wrs_pkg::POR_CYC
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rstn,
    // supply and reset pin
    input  wire logic                    power_good,
    input  wire logic                    reset_pin_n,
    // cpu events
    input  wire logic                    wdt_refresh,
    input  wire logic                    halt_req,
    input  wire logic                    stop_req,
    input  wire logic                    interrupt_any,
    // register access
    input  wire wrs_pkg::wrs_reg_req_t   reg_req,
    input  wire logic [6:0]              irq_low_flags,
    output logic [7:0]                   reg_rdata,
    // wake pins
    input  wire wrs_pkg::wrs_wake_pins_t wake_pins,
    // outputs to pins and core
    output logic                         watchdog_timeout_pin_n,
    output logic                         cpu_reset,
    output logic                         cpu_clk_en,
    output logic                         osc_en,
    output logic [15:0]                  restart_addr
);

    localparam int CW = wrs_pkg::CNT_W;
    localparam int SW = wrs_pkg::SEQ_W;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (WDT_CYC0 < 1 || WDT_CYC1 < 1 || WDT_CYC2 < 1 || WDT_CYC3 < 1 || POR_CYC < 1
            || POR_CYC >= (1 << CW) || WDT_CYC3 >= (1 << CW)) begin : g_bad
            $error("wrs_top: counts must lie between one and the counter range");
        end
    endgenerate

    // ************************************************************
    // registers and state
    // ************************************************************
    wrs_pkg::wrs_state_t state;
    wrs_pkg::wrs_state_t next_state;
    logic [6:0]          stop_rec;
    logic [3:0]          wdt_mode;
    logic                hot_flag;
    logic                wake_cause;
    logic [SW-1:0]       win_cnt;
    logic [SW-1:0]       to_seq;
    logic                to_active;
    logic                loop_seen;
    logic [SW-1:0]       fast_cnt;
    logic                pg_q;

    // ************************************************************
    // register decode
    // ************************************************************
    wire acc_irq  = !reg_req.bank_f && reg_req.addr == wrs_pkg::ADDR_IRQ_FLAGS
                    && (reg_req.rd || reg_req.wr);
    wire wr_smr   = reg_req.bank_f && reg_req.addr == wrs_pkg::ADDR_STOP_REC && reg_req.wr;
    wire rd_smr   = reg_req.bank_f && reg_req.addr == wrs_pkg::ADDR_STOP_REC && reg_req.rd;
    wire win_open = win_cnt < SW'(wrs_pkg::WRITE_WIN_TPC);
    wire wr_wdtm  = reg_req.bank_f && reg_req.addr == wrs_pkg::ADDR_WDT_MODE && reg_req.wr
                    && win_open && !cpu_reset;

    // ************************************************************
    // watchdog run enable and period select
    // ************************************************************
    wire [1:0] per_code = wdt_mode[wrs_pkg::PER_MSB:wrs_pkg::PER_LSB];
    wire [CW-1:0] wdt_period = (per_code == 2'b00) ? CW'(WDT_CYC0) :
                               (per_code == 2'b01) ? CW'(WDT_CYC1) :
                               (per_code == 2'b10) ? CW'(WDT_CYC2) :
                                                     CW'(WDT_CYC3);
    wire wdt_run = (state == wrs_pkg::ST_RUN) || (state == wrs_pkg::ST_RESET)
                   || (state == wrs_pkg::ST_HALT && wdt_mode[wrs_pkg::HALT_RUN])
                   || (state == wrs_pkg::ST_STOP && wdt_mode[wrs_pkg::STOP_RUN]);
    wire wdt_busy;
    wire wdt_done;
    wire power_rise = power_good && !pg_q;
    // power-on arms the watchdog; each refresh re-arms it
    wire wdt_load   = power_rise || wdt_refresh;

    wrs_oneshot #(
        .CNT_W(CW)
    ) u_wdt (
        .clk     (ref_clk),
        .rstn    (rstn),
        .load    (wdt_load),
        .load_val(wdt_period),
        .run     (wdt_run),
        .busy    (wdt_busy),
        .done    (wdt_done)
    );

    // ************************************************************
    // wake source and power-on-reset timer
    // ************************************************************
    wire wake_raw;

    wrs_wake_sel u_wake (
        .pins      (wake_pins),
        .src       (stop_rec[wrs_pkg::SRC_MSB:wrs_pkg::SRC_LSB]),
        .level_high(stop_rec[wrs_pkg::WAKE_LEVEL]),
        .wake      (wake_raw)
    );

    wire in_stop    = state == wrs_pkg::ST_STOP;
    wire slow_wake  = stop_rec[wrs_pkg::POR_ON_WAKE];
    wire smr_wake   = in_stop && wake_raw && (slow_wake ||
                      fast_cnt >= SW'(wrs_pkg::FAST_WAKE_TPC - 1));
    wire loop_rst   = to_active && loop_seen && to_seq == SW'(wrs_pkg::LOOP_RST_TPC - 1);
    wire pin_rst    = !reset_pin_n && !to_active;
    // any source of a fresh reset interval
    wire por_load   = power_rise || pin_rst || loop_rst
                      || (smr_wake && slow_wake);
    wire por_busy;
    wire por_done;

    wrs_oneshot #(
        .CNT_W(CW)
    ) u_por (
        .clk     (ref_clk),
        .rstn    (rstn),
        .load    (por_load),
        .load_val(CW'(POR_CYC)),
        .run     (1'b1),
        .busy    (por_busy),
        .done    (por_done)
    );

    // ************************************************************
    // sleep state machine
    // ************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            wrs_pkg::ST_RESET: begin
                if (por_done && power_good) next_state = wrs_pkg::ST_RUN;
            end
            wrs_pkg::ST_RUN: begin
                if (stop_req) next_state = wrs_pkg::ST_STOP;
                else if (halt_req) next_state = wrs_pkg::ST_HALT;
            end
            wrs_pkg::ST_HALT: begin
                if (interrupt_any) next_state = wrs_pkg::ST_RUN;
            end
            wrs_pkg::ST_STOP: begin
                if (smr_wake && !slow_wake) next_state = wrs_pkg::ST_RUN;
            end
        endcase
        // resets override every state and end stop
        if (por_load || !power_good) next_state = wrs_pkg::ST_RESET;
    end

    // state register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) state <= wrs_pkg::ST_RESET;
        else       state <= next_state;
    end

    // power-good edge detect
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) pg_q <= 1'b0;
        else       pg_q <= power_good;
    end

    // fast-wake qualification: source must stay active for the whole span
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)                   fast_cnt <= '0;
        else if (in_stop && wake_raw && fast_cnt != '1) fast_cnt <= fast_cnt + SW'(1);
        else if (!(in_stop && wake_raw)) fast_cnt <= '0;
    end

    // ************************************************************
    // watchdog time-out pin sequence
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            to_active <= 1'b0;
            to_seq    <= '0;
            loop_seen <= 1'b0;
        end else if (wdt_done) begin
            to_active <= 1'b1;
            to_seq    <= '0;
            loop_seen <= 1'b0;
        end else if (to_active) begin
            to_seq    <= to_seq + SW'(1);
            loop_seen <= loop_seen || !reset_pin_n;
            to_active <= to_seq != SW'(wrs_pkg::LOOP_RST_TPC - 1);
        end
    end

    // pin low for the first six clocks of a time-out
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) watchdog_timeout_pin_n <= 1'b1;
        else       watchdog_timeout_pin_n <= !(wdt_done ||
                   (to_active && to_seq < SW'(wrs_pkg::PIN_LOW_TPC - 1)));
    end

    // ************************************************************
    // write window after reset
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)                 win_cnt <= '0;
        else if (cpu_reset)        win_cnt <= '0;
        else if (win_open)         win_cnt <= win_cnt + SW'(1);
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stop_rec <= wrs_pkg::STOP_REC_RST;
            wdt_mode <= wrs_pkg::WDT_MODE_RST;
        end else begin
            if (wr_smr) stop_rec <= reg_req.wdata[6:0];
            if (wr_wdtm) wdt_mode <= reg_req.wdata[3:0];
        end
    end

    // ************************************************************
    // hot-start and wake-cause flags
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)         hot_flag <= 1'b0;
        else if (wdt_done) hot_flag <= 1'b1;          // set beats clear
        else if (acc_irq)  hot_flag <= 1'b0;
    end

    // wake cause: one after a recovery source, zero after a reset wake
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)                            wake_cause <= 1'b0;
        else if (smr_wake)                    wake_cause <= 1'b1;
        else if (in_stop && (wdt_done || pin_rst)) wake_cause <= 1'b0;
    end

    // ************************************************************
    // read data
    // ************************************************************
    wire [7:0] rd_mux = acc_irq && reg_req.rd ? {hot_flag, irq_low_flags} :
                        rd_smr                ? {wake_cause, 7'h00} : 8'h00;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) reg_rdata <= 8'h00;
        else       reg_rdata <= rd_mux;
    end

    // ************************************************************
    // core controls
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cpu_reset    <= 1'b1;
            cpu_clk_en   <= 1'b0;
            osc_en       <= 1'b1;
            restart_addr <= wrs_pkg::RESTART_ADDR;
        end else begin
            cpu_reset    <= next_state == wrs_pkg::ST_RESET;
            cpu_clk_en   <= next_state == wrs_pkg::ST_RUN;
            osc_en       <= next_state != wrs_pkg::ST_STOP;
            restart_addr <= wrs_pkg::RESTART_ADDR;
        end
    end

endmodule : wrs_top

// ==== dv/wrs_asserts.sv ====
/*
 * concurrent checks on the ports of the watchdog, reset and sleep block.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
module wrs_asserts #(
    parameter int POR_CYC = 100
) (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // inputs seen
    input wire logic        reset_pin_n,
    input wire logic        halt_req,
    input wire logic        stop_req,
    input wire logic        interrupt_any,
    // outputs watched
    input wire logic        watchdog_timeout_pin_n,
    input wire logic        cpu_reset,
    input wire logic        cpu_clk_en,
    input wire logic        osc_en,
    input wire logic [15:0] restart_addr
);
    // ************************************************************
    // helpers
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    int rst_cnt;

    // cycles the core has been held in reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            rst_cnt <= 0;
        else
            rst_cnt <= cpu_reset ? rst_cnt + 1 : 0;
    end

    sequence s_pin_rest;
        (!watchdog_timeout_pin_n) [*5] ##1 watchdog_timeout_pin_n;
    endsequence
    sequence s_looped_out;
        $fell(watchdog_timeout_pin_n) && !cpu_reset ##1 !reset_pin_n;
    endsequence

    // ************************************************************
    // checks
    // ************************************************************
    a_pin_low_six: assert property (
        $fell(watchdog_timeout_pin_n) |=> s_pin_rest) else $error("pin pulse length");
    a_loop_reset_lag: assert property (
        s_looped_out |-> !cpu_reset [*8] ##[6:12] cpu_reset) else $error("loop reset lag");
    a_sleep_stops_clk: assert property (
        (halt_req || stop_req) && cpu_clk_en |=> !cpu_clk_en) else $error("sleep clock");
    a_stop_osc_off: assert property (
        stop_req && cpu_clk_en |=> !osc_en) else $error("stop oscillator");
    a_halt_osc_on: assert property (
        halt_req && !stop_req && cpu_clk_en |=> osc_en) else $error("halt oscillator");
    a_int_ends_halt: assert property (
        interrupt_any && osc_en && !cpu_clk_en && !cpu_reset |-> ##[1:3] cpu_clk_en)
        else $error("halt exit");
    a_reset_no_clk: assert property (
        cpu_reset |-> !cpu_clk_en) else $error("clock in reset");
    a_por_length: assert property (
        $fell(cpu_reset) |-> rst_cnt >= POR_CYC - 2 && rst_cnt <= POR_CYC + 4)
        else $error("reset interval length");
    a_restart_addr: assert property (
        restart_addr == 16'h000C) else $error("restart address");
endmodule : wrs_asserts

bind wrs_top wrs_asserts #(.POR_CYC(POR_CYC)) u_asserts (
    .ref_clk(ref_clk), .rstn(rstn), .reset_pin_n(reset_pin_n), .halt_req(halt_req),
    .stop_req(stop_req), .interrupt_any(interrupt_any),
    .watchdog_timeout_pin_n(watchdog_timeout_pin_n), .cpu_reset(cpu_reset),
    .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .restart_addr(restart_addr));

// ==== dv/wrs_core_model.sv ====
/*
 * partner model: cpu core events and the reset pin wiring.
 * assumes the bench pulses go for one cycle with a command code.
 */
`timescale 1ns/10ps
module wrs_core_model (
    // clock
    input  wire logic       clk,
    // commands from the bench
    input  wire logic       go,
    input  wire logic [1:0] cmd,
    input  wire logic       loop_en,
    // device pins
    input  wire logic       watchdog_timeout_pin_n,
    output logic            reset_pin_n,
    output logic            wdt_refresh,
    output logic            halt_req,
    output logic            stop_req
);
    logic [1:0] take;
    logic [1:0] pend;

    // quiet core at time zero
    initial begin
        wdt_refresh = 1'h0;
        halt_req = 1'h0;
        stop_req = 1'h0;
        pend = 2'h0;
    end

    // pull-up holds the reset pin high unless the time-out pin is wired back
    assign reset_pin_n = loop_en ? watchdog_timeout_pin_n : 1'h1;

    // events change just after the edge; a sleep opcode follows a nop cycle
    always @(posedge clk) begin
        take = go ? cmd : 2'h0;
        #1;
        wdt_refresh = take == 2'h1;
        halt_req = pend == 2'h2;
        stop_req = pend == 2'h3;
        pend = take > 2'h1 ? take : 2'h0;
    end
endmodule : wrs_core_model

// ==== dv/test_watchdog_reset_sleep_control.sv ====
/*
 * self-checking bench of the watchdog, reset and sleep block.
 * assumes shortened watchdog and reset counts set by parameter.
 */
`timescale 1ns/10ps
module test_watchdog_reset_sleep_control;
    localparam int POR = 100;
    int per[4] = '{150, 200, 250, 300};
    logic ref_clk = 0, rstn = 0, power_good = 1, intr = 0, go = 0, loop_en = 1;
    logic [1:0] cmd = '0;
    logic [6:0] irq_low = '0;
    logic [7:0] d, rdata;
    logic [15:0] raddr;
    logic rpin_n, refresh, halt_req, stop_req, pin_n, cpu_reset, clk_en, osc_en;
    wrs_pkg::wrs_reg_req_t req = '0;
    wrs_pkg::wrs_wake_pins_t pins = '1;
    int fails = 0, comparisons = 0, n, k;
    logic hot_m = 0;

    always #2 ref_clk = ~ref_clk;

    wrs_top #(.WDT_CYC0(150), .WDT_CYC1(200), .WDT_CYC2(250), .WDT_CYC3(300),
        .POR_CYC(POR)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .power_good(power_good), .reset_pin_n(rpin_n),
        .wdt_refresh(refresh), .halt_req(halt_req), .stop_req(stop_req),
        .interrupt_any(intr), .reg_req(req), .irq_low_flags(irq_low), .reg_rdata(rdata),
        .wake_pins(pins), .watchdog_timeout_pin_n(pin_n), .cpu_reset(cpu_reset),
        .cpu_clk_en(clk_en), .osc_en(osc_en), .restart_addr(raddr));
    wrs_core_model core_m (.clk(ref_clk), .go(go), .cmd(cmd), .loop_en(loop_en),
        .watchdog_timeout_pin_n(pin_n), .reset_pin_n(rpin_n), .wdt_refresh(refresh),
        .halt_req(halt_req), .stop_req(stop_req));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic step(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic near(input int v, input int lo, input int hi);
        check(16'(v >= lo && v <= hi), 16'h0001);
    endtask : near
    task automatic wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // bounded wait: 0 pin low, 1 reset off, 2 clock on, 3 reset on
    task automatic await(input int sel, output int c);
        c = 0;
        while (!(sel == 0 ? pin_n === 0 : sel == 1 ? cpu_reset === 0 :
                 sel == 2 ? clk_en === 1 : cpu_reset === 1)) begin
            step(1);
            c++;
            if (c > 2000) begin
                fails++;
                $display("[FAIL] %0t wait ran out", $time);
                wrap_up();
            end
        end
    endtask : await
    // one register cycle; read data stands one cycle after the request
    task automatic acc(input logic bank, input logic [7:0] a, input logic w,
                       input logic [7:0] v);
        req = '{bank, a, w, !w, v};
        step(1);
        d = rdata;
        req = '0;
        step(1);
    endtask : acc
    task automatic core(input logic [1:0] c);
        cmd = c;
        go = 1;
        step(1);
        go = 0;
        step(1);
    endtask : core
    // wait for a time-out, then measure how long the pin stays low
    task automatic expire(output int c, output int low);
        await(0, c);
        low = 0;
        while (pin_n === 0 && low < 20) begin
            step(1);
            low++;
        end
        hot_m = 1;
    endtask : expire

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h9c06));
        irq_low = 7'($urandom);
        repeat (10) @(posedge ref_clk);
        #1 rstn = 1;
        await(1, n);
        near(n, POR - 2, POR + 3);
        acc(0, 8'hFA, 0, 8'h00);
        check(d, {hot_m, irq_low});
        acc(1, 8'h0B, 0, 8'h00);
        check(d, 8'h00);
        check(raddr, 16'h000C);
        $display("cold start done");
        for (int c = 0; c < 4; c++) begin
            acc(1, 8'h0F, 1, {6'h03, 2'(c)});
            step($urandom_range(0, 5));
            core(2'h1);
            expire(n, k);
            near(n, per[c] - 2, per[c] + 4);
            check(k, 6);
            await(3, n);
            near(n, 9, 15);
            await(1, n);
            near(n, POR - 3, POR + 3);
            acc(0, 8'hFA, 0, 8'h00);
            check(d[7], hot_m);
            hot_m = 0;
            acc(0, 8'hFA, 0, 8'h00);
            check(d[7], hot_m);
        end
        $display("period table done");
        loop_en = 0;
        rstn = 0;
        step(2);
        rstn = 1;
        expire(n, k);
        near(n, per[0] - 2, per[0] + 4);
        step(20);
        acc(1, 8'h0F, 1, 8'h03);
        core(2'h1);
        core(2'h2);
        step(3);
        check({clk_en, osc_en}, 2'h1);
        expire(n, k);
        near(n, per[0] - 7, per[0] - 1);
        intr = 1;
        await(2, n);
        near(n, 1, 3);
        intr = 0;
        $display("write lock and halt done");
        rstn = 0;
        step(2);
        rstn = 1;
        await(1, n);
        acc(1, 8'h0F, 1, 8'h00);
        acc(1, 8'h0B, 1, 8'h04);
        core(2'h1);
        core(2'h3);
        step(3);
        check({clk_en, osc_en}, 2'h0);
        step(per[0] + 20);
        check(pin_n, 1);
        pins.port0_low[$urandom_range(0, 3)] = 1'h0;
        await(2, n);
        pins = '1;
        near(n, 4, 8);
        check(cpu_reset, 0);
        acc(1, 8'h0B, 0, 8'h00);
        check(d, 8'h80);
        core(2'h1);
        core(2'h2);
        step(per[0] + 20);
        check(pin_n, 1);
        intr = 1;
        await(2, n);
        intr = 0;
        $display("fast wake done");
        acc(1, 8'h0B, 1, 8'h24);
        core(2'h1);
        core(2'h3);
        step(3);
        pins.port0_low[0] = 1'h0;
        await(3, n);
        near(n, 1, 8);
        pins = '1;
        await(1, n);
        near(n, POR - 3, POR + 3);
        acc(1, 8'h0B, 0, 8'h00);
        check(d[7], 1);
        $display("slow wake done");
        wrap_up();
    end
endmodule : test_watchdog_reset_sleep_control
